// ---- rtl/mdma_core.sv ----
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps

// Contract
// - Machine cycle is four oscillator clocks
// - External move lasts two to nine cycles
// - 1 KB SRAM at 0000H-03FFH, move-only
// - SRAM enable bit, cleared by reset
// - Above 03FFH or disabled goes external
// - Scratchpad and data SRAM never alias
// - Second 16-bit data pointer provided
// - Opcode A5H decrements active pointer
// - Select bit 1 uses second pointer
// - Port 0 drives address/data, else released
// - Port 2 drives upper address byte
// - Dedicated read and write strobes
// - Wait pin input-only when enabled
// - Latch strobe precedes data on port 0
module mdma_core (
    input  wire logic        clk_sys,   // 100 MHz oscillator clock
    input  wire logic        srst,      // Synchronous reset, high
    input  wire logic        psel,      // APB select
    input  wire logic        penable,   // APB access phase
    input  wire logic        pwrite,    // APB direction
    input  wire logic [7:0]  paddr,     // APB byte address
    input  wire logic [31:0] pwdata,    // APB write data
    output logic      [31:0] prdata,    // APB read data
    output logic             pready,    // APB ready
    output logic             pslverr,   // APB error, unmapped
    input  wire logic [7:0]  port0In,   // Port 0 pin level
    output logic      [7:0]  port0Out,  // Port 0 address/data
    output logic             port0OeN,  // Port 0 drive, low = on
    output logic      [7:0]  port2Out,  // Port 2 upper address
    output logic             port2OeN,  // Port 2 drive, low = on
    output logic             ale,       // Address latch strobe
    output logic             wrN,       // Write strobe, low
    output logic             rdN,       // Read strobe, low
    input  wire logic        waitIn,    // Wait request from partner
    input  wire logic        p40GpOeN,  // Port 4.0 drive from port
    output logic             p40OeN     // Port 4.0 drive, low = on
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic                    sramEn_ff;
    logic                    ptrSel_ff;
    logic [15:0]             ptr0_ff;
    logic [15:0]             ptr1_ff;
    logic [2:0]              stretch_ff;
    logic                    waitEn_ff;
    logic [7:0]              wdata_ff;
    logic [7:0]              rdata_ff;
    logic                    lastInt_ff;
    mdma_pkg::mdma_state_t   state_ff;
    logic [5:0]              cnt_ff;
    logic [15:0]             addr_ff;
    logic                    isWr_ff;
    logic [31:0]             prdata_ff;
    logic                    err_ff;
    logic [15:0]             activePtr;
    logic                    apbWr, apbSetup, cmdWr, isMove;
    logic                    isWrOp, isDec, sramWe, toInternal;
    logic [7:0]              sramRd;
    logic [5:0]              strobeClks;
    logic [5:0]              strbCnt_ff;
    localparam logic [5:0]   CNT_ONE_L = mdma_pkg::CNT_ONE;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    // Always ready in the access phase; read data prepared at setup
    assign pready   = psel & penable;
    assign pslverr  = psel & penable & err_ff;
    assign prdata   = prdata_ff;
    assign apbSetup = psel & ~penable;
    assign apbWr    = psel & penable & pwrite & ~err_ff;
    // Commands issued while busy are dropped, so only one move at a time
    assign cmdWr    = apbWr && (paddr == mdma_pkg::ADDR_CMD)
                      && (state_ff == mdma_pkg::ST_IDLE);
    assign isWrOp   = (pwdata[7:0] == mdma_pkg::OP_EXTERNAL_DATA_MOVE_INSTR_WR);
    assign isMove   = cmdWr && (isWrOp
                      || (pwdata[7:0] == mdma_pkg::OP_EXTERNAL_DATA_MOVE_INSTR_RD));
    assign isDec    = cmdWr && (pwdata[7:0] == mdma_pkg::OP_DEC_PTR);

    // Unmapped offsets answer with an error and read as zero
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            err_ff    <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else if (apbSetup) begin
            err_ff    <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            case (paddr)
                mdma_pkg::ADDR_PMR:
                    prdata_ff[mdma_pkg::BIT_SRAM_EN] <= sramEn_ff;
                mdma_pkg::ADDR_PSEL:
                    prdata_ff[mdma_pkg::BIT_PTR_SEL] <= ptrSel_ff;
                mdma_pkg::ADDR_PTR0:   prdata_ff[15:0] <= ptr0_ff;
                mdma_pkg::ADDR_PTR1:   prdata_ff[15:0] <= ptr1_ff;
                mdma_pkg::ADDR_XCFG: begin
                    prdata_ff[2:0]                   <= stretch_ff;
                    prdata_ff[mdma_pkg::BIT_WAIT_EN] <= waitEn_ff;
                end
                mdma_pkg::ADDR_CMD:    prdata_ff <= 32'h0000_0000;
                mdma_pkg::ADDR_WDATA:  prdata_ff[7:0] <= wdata_ff;
                mdma_pkg::ADDR_STATUS: begin
                    prdata_ff[7:0]                    <= rdata_ff;
                    prdata_ff[mdma_pkg::BIT_BUSY]     <=
                        (state_ff != mdma_pkg::ST_IDLE);
                    prdata_ff[mdma_pkg::BIT_LAST_INT] <= lastInt_ff;
                end
                default:               err_ff <= 1'b1;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    // SRAM enable starts cleared so the whole space is external
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sramEn_ff <= 1'b0;
        end else if (apbWr && paddr == mdma_pkg::ADDR_PMR) begin
            sramEn_ff <= pwdata[mdma_pkg::BIT_SRAM_EN];
        end
    end

    // Pointer select, access length, wait enable and write byte
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ptrSel_ff  <= 1'b0;
            stretch_ff <= mdma_pkg::RST_STRETCH;
            waitEn_ff  <= 1'b0;
            wdata_ff   <= mdma_pkg::RST_BYTE;
        end else if (apbWr) begin
            if (paddr == mdma_pkg::ADDR_PSEL) begin
                ptrSel_ff <= pwdata[mdma_pkg::BIT_PTR_SEL];
            end
            if (paddr == mdma_pkg::ADDR_XCFG) begin
                stretch_ff <= pwdata[2:0];
                waitEn_ff  <= pwdata[mdma_pkg::BIT_WAIT_EN];
            end
            if (paddr == mdma_pkg::ADDR_WDATA) begin
                wdata_ff <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Dual data pointers
    // ----------------------------------------------------------------
    assign activePtr = ptrSel_ff ? ptr1_ff : ptr0_ff;

    // Decrement wraps 0000H to FFFFH, as a 16-bit counter would
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ptr0_ff <= mdma_pkg::RST_PTR;
            ptr1_ff <= mdma_pkg::RST_PTR;
        end else begin
            if (apbWr && paddr == mdma_pkg::ADDR_PTR0) begin
                ptr0_ff <= pwdata[15:0];
            end else if (isDec && !ptrSel_ff) begin
                ptr0_ff <= ptr0_ff - 16'h0001;
            end
            if (apbWr && paddr == mdma_pkg::ADDR_PTR1) begin
                ptr1_ff <= pwdata[15:0];
            end else if (isDec && ptrSel_ff) begin
                ptr1_ff <= ptr1_ff - 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Address decode and on-chip SRAM
    // ----------------------------------------------------------------
    assign toInternal = sramEn_ff && (activePtr <= mdma_pkg::SRAM_TOP);
    assign sramWe     = isMove && isWrOp && toInternal;

    // Own storage, reached only by the move path, never the scratchpad
    mdma_sram #(
        .DEPTH (mdma_pkg::SRAM_DEPTH),
        .AW    (mdma_pkg::SRAM_AW),
        .DW    (8)
    ) uSram (
        .clk_sys (clk_sys),
        .wrEn    (sramWe),
        .addr    (activePtr[mdma_pkg::SRAM_AW-1:0]),
        .wrData  (wdata_ff),
        .rdData  (sramRd)
    );

    // ----------------------------------------------------------------
    // External access sequencer
    // ----------------------------------------------------------------
    // Strobe phase spans stretch+1 machine cycles, total 2 to 9
    assign strobeClks = 6'(({3'h0, stretch_ff} + mdma_pkg::CNT_ONE)
                           * 6'(mdma_pkg::CLK_PER_MC));

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_ff   <= mdma_pkg::ST_IDLE;
            cnt_ff     <= 6'h00;
            addr_ff    <= mdma_pkg::RST_PTR;
            isWr_ff    <= 1'b0;
            rdata_ff   <= mdma_pkg::RST_BYTE;
            lastInt_ff <= 1'b0;
        end else begin
            case (state_ff)
                mdma_pkg::ST_IDLE: begin
                    cnt_ff <= 6'h00;
                    if (isMove) begin
                        addr_ff    <= activePtr;
                        isWr_ff    <= isWrOp;
                        lastInt_ff <= toInternal;
                        state_ff   <= toInternal ? mdma_pkg::ST_INT
                                                 : mdma_pkg::ST_ADDR;
                    end
                end
                mdma_pkg::ST_ADDR: begin
                    // One machine cycle of address on port 0
                    if (cnt_ff == 6'(mdma_pkg::CLK_PER_MC - 1)) begin
                        cnt_ff   <= 6'h00;
                        state_ff <= mdma_pkg::ST_STROBE;
                    end else begin
                        cnt_ff <= cnt_ff + CNT_ONE_L;
                    end
                end
                mdma_pkg::ST_STROBE: begin
                    if (cnt_ff == strobeClks - 6'h02) begin
                        // Partner may hold the last strobe clock
                        if (!(waitEn_ff && waitIn)) begin
                            if (!isWr_ff) begin
                                rdata_ff <= port0In;
                            end
                            state_ff <= mdma_pkg::ST_HOLD;
                        end
                    end else begin
                        cnt_ff <= cnt_ff + CNT_ONE_L;
                    end
                end
                mdma_pkg::ST_HOLD: begin
                    // Strobe off, data/address held one clock more
                    state_ff <= mdma_pkg::ST_IDLE;
                end
                mdma_pkg::ST_INT: begin
                    if (!isWr_ff) begin
                        rdata_ff <= sramRd;
                    end
                    state_ff <= mdma_pkg::ST_IDLE;
                end
                default: state_ff <= mdma_pkg::ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    // Latch strobe in the first half of the address machine cycle
    assign ale = (state_ff == mdma_pkg::ST_ADDR)
                 && (cnt_ff < 6'(mdma_pkg::ALE_CLKS));
    // Port 0 stays released outside bus cycles and after the address phase of reads
    assign port0Out = (state_ff == mdma_pkg::ST_ADDR) ? addr_ff[7:0]
                                                      : wdata_ff;
    assign port0OeN = !((state_ff == mdma_pkg::ST_ADDR)
                        || (isWr_ff && (state_ff == mdma_pkg::ST_STROBE
                        || state_ff == mdma_pkg::ST_HOLD)));
    assign port2Out = addr_ff[15:8];
    assign port2OeN = !((state_ff == mdma_pkg::ST_ADDR)
                        || (state_ff == mdma_pkg::ST_STROBE)
                        || (state_ff == mdma_pkg::ST_HOLD));
    assign wrN = !((state_ff == mdma_pkg::ST_STROBE) && isWr_ff);
    assign rdN = !((state_ff == mdma_pkg::ST_STROBE) && !isWr_ff);
    // Output driver of the wait pin is parked while waits are enabled
    assign p40OeN = waitEn_ff ? 1'b1 : p40GpOeN;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Counts strobe clocks of the current external access
    always_ff @(posedge clk_sys) begin
        if (srst || state_ff == mdma_pkg::ST_IDLE) begin
            strbCnt_ff <= 6'h00;
        end else if (!rdN || !wrN) begin
            strbCnt_ff <= strbCnt_ff + CNT_ONE_L;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence seqAddrPhase;
        (state_ff == mdma_pkg::ST_ADDR)[*4] ##1
        (state_ff == mdma_pkg::ST_STROBE);
    endsequence
    sequence seqAlePulse;
        ale[*2] ##1 (!ale && !port0OeN)[*2];
    endsequence
    a_mc_addr_len: assert property (
        $rose(state_ff == mdma_pkg::ST_ADDR) |-> seqAddrPhase)
        else $error("Address phase is not one machine cycle");
    a_strobe_len: assert property (
        (state_ff == mdma_pkg::ST_HOLD && !waitEn_ff)
        |-> (strbCnt_ff == strobeClks - 6'h01))
        else $error("Strobe width does not match access length");
    a_int_no_bus: assert property (
        (isMove && toInternal) |=> (state_ff == mdma_pkg::ST_INT)
        && rdN && wrN && !ale ##1 (state_ff == mdma_pkg::ST_IDLE))
        else $error("Internal SRAM access reached the external bus");
    a_sram_reset_off: assert property (
        $fell(srst) |-> !sramEn_ff)
        else $error("SRAM enable not cleared by reset");
    a_ext_route: assert property (
        (isMove && !toInternal) |=> (state_ff == mdma_pkg::ST_ADDR)
        && (addr_ff == $past(activePtr)))
        else $error("External move not routed to the bus");
    a_ptr_dec: assert property (
        isDec |=> (ptrSel_ff ? ptr1_ff : ptr0_ff)
        == $past(activePtr) - 16'h0001)
        else $error("Pointer decrement wrong");
    a_ptr_other_kept: assert property (
        (isDec && ptrSel_ff) |=> $stable(ptr0_ff))
        else $error("Inactive pointer changed on decrement");
    a_port0_write: assert property (
        !wrN |-> !port0OeN && (port0Out == wdata_ff))
        else $error("Port 0 not driving write data");
    a_port0_read: assert property (
        !rdN |-> port0OeN)
        else $error("Port 0 driven during read strobe");
    a_port2_addr: assert property (
        !port0OeN |-> !port2OeN && (port2Out == addr_ff[15:8]))
        else $error("Port 2 not carrying upper address");
    a_wait_input: assert property (
        waitEn_ff |-> p40OeN)
        else $error("Wait pin driven while waits enabled");
    a_ale_first: assert property (
        $rose(state_ff == mdma_pkg::ST_ADDR) |-> seqAlePulse)
        else $error("Latch strobe not ahead of data phase");
endmodule : mdma_core

// ---- rtl/mdma_pkg.sv ----
package mdma_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses on the APB side)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_PMR    = 8'h00; // power_mgmt_register
    localparam logic [7:0] ADDR_PSEL   = 8'h04; // pointer_select
    localparam logic [7:0] ADDR_PTR0   = 8'h08; // first pointer high:low
    localparam logic [7:0] ADDR_PTR1   = 8'h0C; // second pointer high:low
    localparam logic [7:0] ADDR_XCFG   = 8'h10; // external access length
    localparam logic [7:0] ADDR_CMD    = 8'h14; // opcode issue
    localparam logic [7:0] ADDR_WDATA  = 8'h18; // write data byte
    localparam logic [7:0] ADDR_STATUS = 8'h1C; // read data and state

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int         BIT_SRAM_EN  = 0;
    localparam int         BIT_PTR_SEL  = 0;
    localparam int         BIT_WAIT_EN  = 4;
    localparam int         BIT_BUSY     = 8;
    localparam int         BIT_LAST_INT = 9;
    localparam logic [2:0] RST_STRETCH  = 3'h7;   // slowest access
    localparam logic [15:0] RST_PTR     = 16'h0000;
    localparam logic [7:0] RST_BYTE     = 8'h00;

    // ----------------------------------------------------------------
    // Opcodes accepted on the command register
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_DEC_PTR  = 8'hA5;
    localparam logic [7:0] OP_EXTERNAL_DATA_MOVE_INSTR_RD  = 8'hE0;
    localparam logic [7:0] OP_EXTERNAL_DATA_MOVE_INSTR_WR  = 8'hF0;

    // ----------------------------------------------------------------
    // Memory map and timing
    // ----------------------------------------------------------------
    localparam logic [15:0] SRAM_TOP   = 16'h03FF;
    localparam int          SRAM_DEPTH = 1024;
    localparam int          SRAM_AW    = 10;
    localparam int          CLK_PER_MC = 4;   // oscillator clocks per cycle
    localparam int          ALE_CLKS   = 2;   // latch strobe width
    localparam logic [5:0]  CNT_ONE    = 6'h01;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_ADDR   = 3'b001,
        ST_STROBE = 3'b010,
        ST_HOLD   = 3'b011,
        ST_INT    = 3'b100
    } mdma_state_t;

endpackage : mdma_pkg

// ---- rtl/mdma_sram.sv ----
`timescale 1ns/1ps

module mdma_sram #(
    parameter int DEPTH = 1024,
    parameter int AW    = 10,
    parameter int DW    = 8
) (
    input  wire logic          clk_sys, // System clock
    input  wire logic          wrEn,    // Write strobe, one cycle
    input  wire logic [AW-1:0] addr,    // Word address
    input  wire logic [DW-1:0] wrData,  // Write data
    output logic      [DW-1:0] rdData   // Registered read data
);

    logic [DW-1:0] mem [DEPTH];

    // Synchronous write; read data registered so it never glitches
    always_ff @(posedge clk_sys) begin
        if (wrEn) begin
            mem[addr] <= wrData;
        end
        rdData <= mem[addr];
    end

endmodule : mdma_sram

// ---- tb/external_data_move_instr_data_memory_access_tb.sv ----
`timescale 1ns/1ps

module external_data_move_instr_data_memory_access_tb;
    logic clk_sys = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00, port0Out, port2Out, memData;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic pready, pslverr, port0OeN, port2OeN, ale, wrN, rdN, waitIn;
    logic p40GpOeN = 0, p40OeN, slow = 0, e;
    logic [15:0] expAddr = 16'h0000;
    int errors = 0, compares = 0, cyc = 0, strb = 0, aleN = 0, bad = 0;

    always #5 clk_sys = ~clk_sys;

    mdma_core dut_u (.clk_sys(clk_sys), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port0In(port0OeN ? memData : port0Out), .port0Out(port0Out),
        .port0OeN(port0OeN), .port2Out(port2Out), .port2OeN(port2OeN),
        .ale(ale), .wrN(wrN), .rdN(rdN), .waitIn(waitIn),
        .p40GpOeN(p40GpOeN), .p40OeN(p40OeN));

    mdma_ext_ram ram_u (.clk_sys(clk_sys), .ale(ale), .port0Out(port0Out),
        .port2Out(port2Out), .rdN(rdN), .wrN(wrN), .slow(slow),
        .waitIn(waitIn), .dataOut(memData));

    // ----------------------------------------------------------------
    // Bus watcher: strobe and latch clocks, pin drive during strobes
    // ----------------------------------------------------------------
    always @(posedge clk_sys) begin
        cyc++;
        if (!rdN || !wrN) begin
            strb++;
            if (port2OeN !== 1'b0 || port2Out !== expAddr[15:8]) bad++;
        end
        if (!wrN && port0OeN !== 1'b0) bad++;
        if (!rdN && port0OeN !== 1'b1) bad++;
        if (ale === 1'b1) aleN++;
        if (cyc == 30000) begin
            errors++;
            print_verdict();
        end
    end

    task automatic cmp(string n, logic [31:0] x, logic [31:0] g);
        compares++;
        if (g !== x) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask : cmp

    // Setup then access phase; hold everything until pready is seen
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    task automatic wr(logic [7:0] a, logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdc(string n, logic [7:0] a, logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        cmp(n, x, r);
    endtask : rdc

    // Issue one opcode and poll the busy flag until it clears
    task automatic cmd(logic [7:0] op);
        strb = 0;
        aleN = 0;
        wr(mdma_pkg::ADDR_CMD, {24'h00_0000, op});
        do apb(1'b0, mdma_pkg::ADDR_STATUS, 0);
        while (r[mdma_pkg::BIT_BUSY] !== 1'b0);
    endtask : cmd

    task automatic print_verdict;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (2) @(posedge clk_sys);
        srst <= 0;
        rdc("pmr", mdma_pkg::ADDR_PMR, 0);
        rdc("xcfg", mdma_pkg::ADDR_XCFG, 32'h0000_0007);
        rdc("psel", mdma_pkg::ADDR_PSEL, 0);
        $display("test reset done");
        wr(mdma_pkg::ADDR_PTR0, 0);
        cmd(mdma_pkg::OP_DEC_PTR);
        rdc("ptr0", mdma_pkg::ADDR_PTR0, 32'h0000_FFFF);
        wr(mdma_pkg::ADDR_PTR1, 32'h0000_1234);
        wr(mdma_pkg::ADDR_PSEL, 1);
        cmd(mdma_pkg::OP_DEC_PTR);
        rdc("ptr1", mdma_pkg::ADDR_PTR1, 32'h0000_1233);
        rdc("ptr0", mdma_pkg::ADDR_PTR0, 32'h0000_FFFF);
        wr(mdma_pkg::ADDR_PSEL, 0);
        $display("test pointers done");
        for (int s = 0; s < 8; s++) begin
            expAddr = 16'h0100 + 16'(s);
            wr(mdma_pkg::ADDR_XCFG, s);
            wr(mdma_pkg::ADDR_PTR0, {16'h0000, expAddr});
            wr(mdma_pkg::ADDR_WDATA, 32'h30 + s);
            cmd(mdma_pkg::OP_EXTERNAL_DATA_MOVE_INSTR_WR);
            cmp("strobes", 4 * (s + 1) - 1, strb);
            cmp("ale", mdma_pkg::ALE_CLKS, aleN);
            cmp("extmem", 32'h30 + s, ram_u.mem[expAddr]);
            cmd(mdma_pkg::OP_EXTERNAL_DATA_MOVE_INSTR_RD);
            rdc("rdbyte", mdma_pkg::ADDR_STATUS, 32'h30 + s);
        end
        $display("test external done");
        wr(mdma_pkg::ADDR_PMR, 1);
        wr(mdma_pkg::ADDR_PTR0, 32'h0000_03FF);
        wr(mdma_pkg::ADDR_WDATA, 32'h0000_00C3);
        cmd(mdma_pkg::OP_EXTERNAL_DATA_MOVE_INSTR_WR);
        cmp("intstrb", 0, strb);
        wr(mdma_pkg::ADDR_WDATA, 0);
        cmd(mdma_pkg::OP_EXTERNAL_DATA_MOVE_INSTR_RD);
        rdc("intrd", mdma_pkg::ADDR_STATUS, 32'h0000_02C3);
        expAddr = 16'h0400;
        wr(mdma_pkg::ADDR_PTR0, 32'h0000_0400);
        wr(mdma_pkg::ADDR_WDATA, 32'h0000_0077);
        cmd(mdma_pkg::OP_EXTERNAL_DATA_MOVE_INSTR_WR);
        cmp("above", 32'h77, ram_u.mem[expAddr]);
        wr(mdma_pkg::ADDR_PMR, 0);
        expAddr = 16'h0101;
        wr(mdma_pkg::ADDR_PTR0, 32'h0000_0101);
        cmd(mdma_pkg::OP_EXTERNAL_DATA_MOVE_INSTR_RD);
        rdc("offmap", mdma_pkg::ADDR_STATUS, 32'h0000_0031);
        $display("test sram map done");
        p40GpOeN <= 1;
        @(posedge clk_sys);
        cmp("p40gp", 1, p40OeN);
        p40GpOeN <= 0;
        @(posedge clk_sys);
        cmp("p40", 0, p40OeN);
        wr(mdma_pkg::ADDR_XCFG, 32'h0000_0010);
        // Enable lands at the access edge; look one clock later
        @(posedge clk_sys);
        cmp("p40wait", 1, p40OeN);
        slow <= 1;
        cmd(mdma_pkg::OP_EXTERNAL_DATA_MOVE_INSTR_RD);
        cmp("stretch", 1, strb > 3);
        rdc("waitrd", mdma_pkg::ADDR_STATUS, 32'h0000_0031);
        slow <= 0;
        $display("test wait done");
        apb(1'b0, 8'h20, 0);
        cmp("slverr", 1, e);
        cmp("unmapped", 0, r);
        cmp("pindrive", 0, bad);
        $display("test unmapped done");
        print_verdict();
    end
endmodule : external_data_move_instr_data_memory_access_tb

// ---- tb/mdma_ext_ram.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// External data RAM on the multiplexed bus
// ----------------------------------------------------------------
module mdma_ext_ram (
    input  wire logic       clk_sys, // Oscillator clock
    input  wire logic       ale,     // Address latch strobe
    input  wire logic [7:0] port0Out,// Low address / write byte
    input  wire logic [7:0] port2Out,// Upper address
    input  wire logic       rdN,     // Read strobe, low
    input  wire logic       wrN,     // Write strobe, low
    input  wire logic       slow,    // Ask for wait states
    output logic            waitIn,  // Wait request
    output logic      [7:0] dataOut  // Byte driven on port 0
);
    logic [7:0]  mem [65536];
    logic [15:0] addr_ff;
    logic [7:0]  last_ff;
    logic [3:0]  strb_ff;

    // Address is captured from port 2 and port 0 on each clock while the latch strobe is high
    always_ff @(posedge clk_sys) begin
        if (ale) begin
            addr_ff <= {port2Out, port0Out};
        end
        if (!wrN) begin
            mem[addr_ff] <= port0Out;
        end
    end

    // Count strobe clocks so a slow part can hold off the end
    always_ff @(posedge clk_sys) begin
        strb_ff <= (!rdN || !wrN) ? strb_ff + 4'h1 : 4'h0;
        if (!rdN) begin
            last_ff <= mem[addr_ff];
        end
    end

    // Released bus shows the inverse of the last byte, not a held value
    assign dataOut = !rdN ? mem[addr_ff] : ~last_ff;
    assign waitIn  = slow && (!rdN || !wrN) && (strb_ff < 4'h6);
endmodule : mdma_ext_ram
